// >>> sim/hbgc_gate_model.sv
// Purpose: Behavioural gate driver seen at its logic pins
// Assumes: Times in ns; both flags are open collector
// Notes:   Faults are injected by the bench
module hbgc_gate_model (
  input wire hbgc_pkg::hbgc_drive_t drive, // Pins from host
  input wire logic short_in, // Injected short
  input wire logic uv_in, // Injected undervoltage
  input wire logic ot_in, // Injected overtemperature
  output logic sd_pull, // Sinks shutdown flag
  output logic cause_pull // Sinks cause flag
);
  timeunit 1ns;
  timeprecision 1ns;
  import hbgc_pkg::*;
  realtime t_dis = 0;
  realtime t_sc = 0;
  logic latched = 0;
  logic off = 0;
  logic act;
  ////////////////////
  // Stamps restart at each rise, so short episodes never add up
  always @(posedge drive.deadtime_disable_input) t_dis = $realtime;
  always @(posedge short_in) t_sc = $realtime;
  // Of the disable pulses, only one inside the clear window drops the latch
  always @(negedge drive.deadtime_disable_input)
    if ($realtime - t_dis >= 3100 &&
        $realtime - t_dis <= 3600) latched = 0;
  // Waking up reinitialises the device
  always @(posedge drive.sleep_control_input) latched = 0;
  // Polled every 100 ns; a clear pulse is too short to shut down
  always #100 begin
    off = drive.deadtime_disable_input && $realtime - t_dis > 7000;
    if (short_in && $realtime - t_sc >= 9000 && act)
      latched = 1;
  end
  ////////////////////
  // Flags released while asleep or shut down
  assign act = drive.sleep_control_input && !off;
  // High-side gates per the bridge truth table; delays are ignored
  logic gh1, gh2, gates_on, pump;
  assign gates_on = drive.sleep_control_input &&
    !drive.deadtime_disable_input;
  assign gh1 = gates_on && (!drive.pwm || !drive.dir);
  assign gh2 = gates_on && (!drive.pwm || drive.dir);
  // Charge pump only tops up a high side that is on
  assign pump = gh1 || gh2;
  always_comb begin
    sd_pull = act && (uv_in || latched);
    cause_pull = act && (uv_in || (ot_in && !latched));
  end
endmodule : hbgc_gate_model

// >>> sim/hbgc_host_sva.sv
// Purpose: Port checks of the gate driver host controller
// Assumes: One clock, synchronous active high reset
// Notes:   Bound to hbgc_host below
module hbgc_host_sva #(
  parameter int HS_MAX_ON = hbgc_pkg::HS_MAX_ON_CYC // Refresh limit cycles
) (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire hbgc_pkg::hbgc_drive_t drive // Driver pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import hbgc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [31:0] hi_reg, hi_next, lo_reg, lo_next, st_reg, st_next;
  logic [1:0] pd_reg;
  ////////////////////
  // Run lengths: disable high, pwm low, pattern pins unchanged
  always_comb begin
    hi_next = drive.deadtime_disable_input ? hi_reg + 1 : '0;
    lo_next = drive.pwm ? '0 : lo_reg + 1;
    st_next = (drive.sleep_control_input && !drive.deadtime_disable_input &&
      {drive.pwm, drive.dir} == pd_reg) ? st_reg + 1 : '0;
  end
  always_ff @(posedge sys_clk) begin
    hi_reg <= reset ? '0 : hi_next;
    lo_reg <= reset ? '0 : lo_next;
    st_reg <= reset ? '0 : st_next;
    pd_reg <= {drive.pwm, drive.dir};
  end
  ////////////////////
  a_reset_pins: assert property ($fell(reset) |->
    drive.deadtime_disable_input && !drive.sleep_control_input)
    else $error("pins not safe after reset");
  a_wake_hold: assert property ($rose(drive.sleep_control_input) |->
    drive.deadtime_disable_input [*8]) else $error("enabled at wake");
  a_pulse_len: assert property ($fell(drive.deadtime_disable_input) |->
    hi_reg inside {[78:90]} || hi_reg > 175) else $error("bad pulse");
  a_low_gap: assert property ($rose(drive.pwm) &&
    !drive.deadtime_disable_input |-> lo_reg >= 25) else $error("short gap");
  a_refresh_len: assert property (st_reg <= HS_MAX_ON)
    else $error("no refresh");
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("pready low");
  a_map_err: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > 8'h14)) else $error("pslverr wrong");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved");
endmodule : hbgc_host_sva
bind hbgc_host hbgc_host_sva #(.HS_MAX_ON(HS_MAX_ON)) u_sva (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive(drive));

// >>> sim/hbgc_host_test.sv
// Purpose: Self-checking bench of the gate driver host controller
// Assumes: 25 MHz clock, APB master tasks, behavioural driver
// Notes:   Refresh limit cut to 200 cycles for a short run
module hbgc_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  import hbgc_pkg::*;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, sd_pull, cause_pull;
  logic short_in = 0, uv_in = 0, ot_in = 0;
  hbgc_drive_t drive;
  hbgc_flags_t flags_pin;
  int fail_count = 0, tests_run = 0, cyc = 0, n, i;
  // Pulled up unless the driver sinks them
  assign flags_pin = {!sd_pull, !cause_pull};
  hbgc_host #(.HS_MAX_ON(200)) u_dut (.sys_clk(sys_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive(drive), .flags_pin(flags_pin));
  hbgc_gate_model u_dev (.drive(drive), .short_in(short_in),
    .uv_in(uv_in), .ot_in(ot_in), .sd_pull(sd_pull),
    .cause_pull(cause_pull));
  initial forever #20 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      end_sim();
    end
  end
  ////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until pready is seen, no fixed wait assumed
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] exp, input logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    if (!wr) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic hi_cnt(input int len, input bit use_dir);
    n = 0;
    repeat (len) begin
      @(posedge sys_clk);
      n += use_dir ? drive.dir : drive.pwm;
    end
  endtask : hi_cnt
  task automatic duty(input logic [31:0] d, input int len);
    apb(1, DUTY_OFS, d, 0, 0);
    tick(100);
    hi_cnt(len, 0);
  endtask : duty
  ////////////////////
  initial begin
    tick(20);
    reset <= 1'b0;
    apb(0, CTRL_OFS, 0, 0, 0);
    apb(0, PERIOD_OFS, 0, {16'h0, PERIOD_RST}, 0);
    apb(0, BOOT_OFS, 0, {16'h0, BOOT_RST}, 0);
    apb(0, STATUS_OFS, 0, 32'h3, 0);
    apb(0, 8'h20, 0, 0, 1);
    $display("registers done");
    apb(1, BOOT_OFS, 32'hc8, 0, 0);
    apb(1, CTRL_OFS, 32'h1, 0, 0);
    tick(4);
    chk({drive.sleep_control_input, drive.deadtime_disable_input}, 3);
    apb(0, STATUS_OFS, 0, 32'h13, 0);
    tick(220);
    apb(1, PERIOD_OFS, 32'h64, 0, 0);
    apb(1, CTRL_OFS, 32'h3, 0, 0);
    tick(4);
    chk({31'h0, drive.deadtime_disable_input}, 0);
    chk({30'h0, u_dev.gh1, u_dev.gh2}, 3);
    duty(32'h0, 450);
    chk(n, 50);
    duty(32'h63, 100);
    chk(n, 75);
    duty(32'h32, 100);
    chk(n, 50);
    $display("start-up and pattern done");
    uv_in <= 1'b1;
    tick(6);
    apb(0, STATUS_OFS, 0, 32'h2c, 0);
    uv_in <= 1'b0;
    ot_in <= 1'b1;
    tick(6);
    apb(0, STATUS_OFS, 0, 32'h26, 0);
    ot_in <= 1'b0;
    // Three episodes, each under the filter time
    repeat (3) begin
      short_in <= 1'b1;
      tick(125);
      short_in <= 1'b0;
      tick(5);
    end
    apb(0, STATUS_OFS, 0, 32'h23, 0);
    short_in <= 1'b1;
    tick(250);
    short_in <= 1'b0;
    tick(6);
    apb(0, STATUS_OFS, 0, 32'h29, 0);
    $display("faults done");
    apb(1, CMD_OFS, 32'h1, 0, 0);
    for (i = 0; i < 20 && drive.deadtime_disable_input !== 1'b1; i++)
      @(posedge sys_clk);
    n = 0;
    while (drive.deadtime_disable_input === 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n, CLR_PULSE_CYC);
    tick(6);
    apb(0, STATUS_OFS, 0, 32'h23, 0);
    apb(0, CMD_OFS, 0, 0, 0);
    $display("clear done");
    apb(1, CTRL_OFS, 32'h1, 0, 0);
    tick(200);
    apb(0, STATUS_OFS, 0, 32'h43, 0);
    chk({31'h0, drive.deadtime_disable_input}, 1);
    apb(1, CTRL_OFS, 32'h5, 0, 0);
    apb(1, CTRL_OFS, 32'h7, 0, 0);
    tick(260);
    hi_cnt(100, 1);
    chk(n, 50);
    chk({31'h0, drive.pwm}, 1);
    $display("off and fast decay done");
    apb(1, CTRL_OFS, 32'h0, 0, 0);
    tick(4);
    chk({31'h0, drive.sleep_control_input}, 0);
    apb(0, STATUS_OFS, 0, 32'h3, 0);
    $display("sleep done");
    end_sim();
  end
endmodule : hbgc_host_test

// >>> src/hbgc_host.sv
// Purpose: Host-side controller driving an H-bridge gate driver's pins
// Assumes: APB slave with zero wait states, one 25 MHz clock
// Notes:   Sequencing start-up, diagnosis clear, PWM with bootstrap care
//
// The implementer's own choices: the address map and register access over APB.
module hbgc_host #(
  parameter int HS_MAX_ON = hbgc_pkg::HS_MAX_ON_CYC // Refresh limit cycles
) (
  input wire logic sys_clk,                    // 25 MHz clock
  input wire logic reset,                      // Synchronous, active high
  input wire logic psel,                       // APB select
  input wire logic penable,                    // APB access phase
  input wire logic pwrite,                     // APB direction
  input wire logic [7:0] paddr,                // APB byte address
  input wire logic [31:0] pwdata,              // APB write data
  output logic [31:0] prdata,                  // APB read data
  output logic pready,                         // APB ready
  output logic pslverr,                        // APB error, unmapped
  output hbgc_pkg::hbgc_drive_t drive,         // Pins to the driver
  input wire hbgc_pkg::hbgc_flags_t flags_pin  // Fault flags, asynchronous
);
  import hbgc_pkg::*;

  typedef enum logic [2:0] {
    ST_SLEEP, ST_BOOT, ST_RUN, ST_CLEAR, ST_OFF
  } hbgc_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Flag synchroniser: open-collector pins are outside our clock
  hbgc_flags_t flags_s1_reg;
  hbgc_flags_t flags_s2_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_s1_reg <= 2'b11;
      flags_s2_reg <= 2'b11;
    end else begin
      flags_s1_reg <= flags_pin;
      flags_s2_reg <= flags_s1_reg;
    end
  end

  // Decode of the flag pair; idle pull-ups read high
  function automatic hbgc_fault_t decode_flags(input hbgc_flags_t f);
    if (f.fault_shutdown_flag && f.fault_cause_flag)
      decode_flags = HBGC_OK;
    else if (f.fault_shutdown_flag)
      decode_flags = HBGC_OVERTEMP;
    else if (f.fault_cause_flag)
      decode_flags = HBGC_SHORT;
    else
      decode_flags = HBGC_UNDERVOLT;
  endfunction : decode_flags

  hbgc_fault_t fault_now;
  assign fault_now = decode_flags(flags_s2_reg);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [3:0] ctrl_reg, ctrl_next;
  logic [15:0] period_reg, period_next;
  logic [15:0] duty_reg, duty_next;
  logic [15:0] boot_reg, boot_next;
  logic clr_pend_reg, clr_pend_next;
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;
  hbgc_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;

  logic wr_acc;
  logic setup;
  logic clr_taken;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign clr_taken = (state_reg == ST_RUN) && clr_pend_reg;

  // Address check used by the error logic for reads and writes
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL_OFS) || (a == CMD_OFS) || (a == PERIOD_OFS) ||
             (a == DUTY_OFS) || (a == BOOT_OFS) || (a == STATUS_OFS);
  endfunction : mapped

  // Register writes, read capture in setup so data is flopped at access
  always_comb begin
    ctrl_next = ctrl_reg;
    period_next = period_reg;
    duty_next = duty_reg;
    boot_next = boot_reg;
    clr_pend_next = clr_pend_reg;
    prdata_next = prdata_reg;
    err_next = err_reg;
    if (clr_taken)
      clr_pend_next = 1'b0;
    if (wr_acc) begin
      if (paddr == CTRL_OFS) begin
        ctrl_next = pwdata[3:0];
      end else if (paddr == CMD_OFS) begin
        // Set wins over the consume in the same cycle
        if (pwdata[CMD_CLEAR_BIT])
          clr_pend_next = 1'b1;
      end else if (paddr == PERIOD_OFS) begin
        period_next = pwdata[15:0];
      end else if (paddr == DUTY_OFS) begin
        duty_next = pwdata[15:0];
      end else if (paddr == BOOT_OFS) begin
        boot_next = pwdata[15:0];
      end
    end
    if (setup) begin
      err_next = !mapped(paddr);
      prdata_next = 32'h0000_0000;
      if (paddr == CTRL_OFS) begin
        prdata_next = {28'h0000000, ctrl_reg};
      end else if (paddr == CMD_OFS) begin
        prdata_next = {31'h00000000, clr_pend_reg};
      end else if (paddr == PERIOD_OFS) begin
        prdata_next = {16'h0000, period_reg};
      end else if (paddr == DUTY_OFS) begin
        prdata_next = {16'h0000, duty_reg};
      end else if (paddr == BOOT_OFS) begin
        prdata_next = {16'h0000, boot_reg};
      end else if (paddr == STATUS_OFS) begin
        prdata_next = {25'h0, state_reg, fault_now, flags_s2_reg};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RST;
      period_reg <= PERIOD_RST;
      duty_reg <= DUTY_RST;
      boot_reg <= BOOT_RST;
      clr_pend_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      period_reg <= period_next;
      duty_reg <= duty_next;
      boot_reg <= boot_next;
      clr_pend_reg <= clr_pend_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = psel && penable && err_reg;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer for sleep, bootstrap charging, clear pulse and shutdown
  logic awake;
  logic run;
  assign awake = ctrl_reg[CTRL_AWAKE_BIT];
  assign run = ctrl_reg[CTRL_RUN_BIT];

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 16'h0001;
    case (state_reg)
      ST_SLEEP: begin
        // Waking reinitialises the driver, so always recharge first
        if (awake) begin
          state_next = ST_BOOT;
          cnt_next = 16'h0000;
        end
      end
      ST_BOOT: begin
        // Disable stays high while bootstraps charge
        if (!awake) begin
          state_next = ST_SLEEP;
        end else if (cnt_reg >= boot_reg && run) begin
          state_next = ST_RUN;
          cnt_next = 16'h0000;
        end else if (cnt_reg >= boot_reg) begin
          cnt_next = cnt_reg;
        end
      end
      ST_RUN: begin
        cnt_next = 16'h0000;
        if (!awake)
          state_next = ST_SLEEP;
        else if (!run)
          state_next = ST_OFF;
        else if (clr_pend_reg)
          state_next = ST_CLEAR;
      end
      ST_CLEAR: begin
        // Pulse length sits inside the clear window, far below shutdown
        if (cnt_reg == 16'(CLR_PULSE_CYC - 1)) begin
          state_next = ST_RUN;
          cnt_next = 16'h0000;
        end
      end
      ST_OFF: begin
        cnt_next = 16'h0000;
        if (!awake)
          state_next = ST_SLEEP;
        else if (run)
          state_next = ST_BOOT;
      end
      default: begin
        state_next = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_SLEEP;
      cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM pattern with a charging gap each period and long-on refresh
  logic [15:0] pcnt_reg, pcnt_next;
  logic [15:0] duty_lim;
  logic pat_raw;
  logic pat_reg, pat_next;
  logic [15:0] hold_reg, hold_next;
  logic [15:0] fresh_reg, fresh_next;
  logic pat_out;

  // Keep a charging gap of low and high time per period, except at duty 0, duty at or above the period, or a period of 50 cycles or less
  always_comb begin
    if (period_reg <= 16'(2 * REFRESH_CYC))
      duty_lim = 16'h0000;
    else if (duty_reg == 16'h0000 || duty_reg >= period_reg)
      duty_lim = duty_reg;
    else if (duty_reg > period_reg - 16'(REFRESH_CYC))
      duty_lim = period_reg - 16'(REFRESH_CYC);
    else if (duty_reg < 16'(REFRESH_CYC))
      duty_lim = 16'(REFRESH_CYC);
    else
      duty_lim = duty_reg;
  end

  assign pat_raw = (pcnt_reg < duty_lim);
  assign pat_out = (fresh_reg != 16'h0000) ? !pat_reg : pat_reg;

  always_comb begin
    pcnt_next = (pcnt_reg + 16'h0001 >= period_reg) ? 16'h0000 :
                pcnt_reg + 16'h0001;
    pat_next = pat_raw;
    hold_next = hold_reg;
    fresh_next = fresh_reg;
    if (fresh_reg != 16'h0000) begin
      fresh_next = fresh_reg - 16'h0001;
      hold_next = 16'h0000;
    end else if (pat_raw != pat_reg) begin
      hold_next = 16'h0000;
    end else if (hold_reg >= 16'(HS_MAX_ON - 1)) begin
      // A level held this long starves the bootstrap: flip briefly
      fresh_next = 16'(REFRESH_CYC);
      hold_next = 16'h0000;
    end else begin
      hold_next = hold_reg + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    // Pattern keeps running through a clear pulse
    if (reset || (state_reg != ST_RUN && state_reg != ST_CLEAR)) begin
      pcnt_reg <= 16'h0000;
      pat_reg <= 1'b0;
      hold_reg <= 16'h0000;
      fresh_reg <= 16'h0000;
    end else begin
      pcnt_reg <= pcnt_next;
      pat_reg <= pat_next;
      hold_reg <= hold_next;
      fresh_reg <= fresh_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive, all from flip-flops
  hbgc_drive_t drive_reg, drive_next;

  always_comb begin
    drive_next.sleep_control_input = (state_reg != ST_SLEEP);
    // Low level only while running; dead time stays with the driver
    drive_next.deadtime_disable_input = (state_reg != ST_RUN);
    drive_next.pwm = 1'b0;
    drive_next.dir = 1'b0;
    if (state_reg == ST_RUN || state_reg == ST_CLEAR) begin
      if (ctrl_reg[CTRL_FAST_BIT]) begin
        drive_next.pwm = 1'b1;
        drive_next.dir = pat_out;
      end else begin
        drive_next.pwm = pat_out;
        drive_next.dir = ctrl_reg[CTRL_DIR_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset)
      drive_reg <= 4'b0100;
    else
      drive_reg <= drive_next;
  end

  assign drive = drive_reg;

endmodule : hbgc_host

// >>> src/hbgc_pkg.sv
// Purpose: Constants and carriers for the H-bridge gate driver controller
// Assumes: sys_clk at 25 MHz, APB register access from software
// Notes:   Pulse, refresh and on-time limits are kept in ns and converted to cycles here; register reset values are in cycles
// Functional notes
// - Fault flags open collector, both high idle
// - Hold disabled until bootstraps charged, then pattern
// - Break high-side on-time over 1ms with 1us
// - Each PWM period leaves about 1us charging, except at duty 0, full duty or a period of 2us or less
// - Fast decay: PWM at 1, modulate direction
package hbgc_pkg;
  localparam int CLK_MHZ = 25;
  // Diagnosis clear pulse: centred in the 3.1 to 3.6 us window
  localparam int CLR_PULSE_NS = 3350;
  localparam int CLR_PULSE_CYC = (CLR_PULSE_NS * CLK_MHZ + 999) / 1000;
  // Refresh / charging gap for the bootstrap capacitor
  localparam int REFRESH_NS = 1000;
  localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ + 999) / 1000;
  // Longest constant high-side on-time, as a parameter default
  localparam int HS_MAX_ON_NS = 1000000;
  localparam int HS_MAX_ON_CYC = HS_MAX_ON_NS * CLK_MHZ / 1000;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] PERIOD_OFS = 8'h08;
  localparam logic [7:0] DUTY_OFS = 8'h0c;
  localparam logic [7:0] BOOT_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // CTRL and CMD field positions
  localparam int CTRL_AWAKE_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_DIR_BIT = 3;
  localparam int CMD_CLEAR_BIT = 0;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] PERIOD_RST = 16'h04e2;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] BOOT_RST = 16'h2710;

  typedef enum logic [1:0] {
    HBGC_OK, HBGC_OVERTEMP, HBGC_SHORT, HBGC_UNDERVOLT
  } hbgc_fault_t;

  // Pins driven toward the gate driver
  typedef struct packed {
    logic sleep_control_input;    // High keeps the driver awake
    logic deadtime_disable_input; // High = disable/clear level
    logic pwm;
    logic dir;
  } hbgc_drive_t;

  // Open-collector flags read back from the driver
  typedef struct packed {
    logic fault_shutdown_flag;
    logic fault_cause_flag;
  } hbgc_flags_t;
endpackage : hbgc_pkg
